/* File: shared/sensor_cmd_pkg.sv */
// Purpose: constants and carriers for the maintenance and single-shot
//          command interpreter
// Assumes: 40 MHz core clock
// Notes: times in ms, calibration interval in minutes, cycle counts derived from the clock rate
package sensor_cmd_pkg;

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [15:0] CMD_SELF_TEST = 16'h3639;
  localparam logic [15:0] CMD_FACTORY_RESET = 16'h3632;
  localparam logic [15:0] CMD_REINIT = 16'h3646;
  localparam logic [15:0] CMD_SINGLE_SHOT = 16'h219D;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 40000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int SELF_TEST_MS = 10000;
  localparam int FACTORY_RESET_MS = 1200;
  localparam int REINIT_MS = 20;
  localparam int SINGLE_SHOT_MS = 5000;
  localparam int ASC_INTERVAL_MIN = 5;
  localparam int SELF_TEST_CYC = SELF_TEST_MS * CYC_PER_MS;
  localparam int FACTORY_RESET_CYC = FACTORY_RESET_MS * CYC_PER_MS;
  localparam int REINIT_CYC = REINIT_MS * CYC_PER_MS;
  localparam int SINGLE_SHOT_CYC = SINGLE_SHOT_MS * CYC_PER_MS;
  // five minutes of cycles overflows 32 bits, so this count is 64-bit
  localparam longint ASC_INTERVAL_CYC =
    longint'(ASC_INTERVAL_MIN) * 60000 * CYC_PER_MS;

  // ************************************************************
  // response format and reset values
  // ************************************************************
  localparam int RESULT_BYTES = 3;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic ASC_EN_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SELF_TEST, ST_FACTORY, ST_REINIT, ST_SHOT
  } cmd_state_t;

  // measurement data carried together
  typedef struct packed {
    logic [15:0] gas;
    logic [15:0] humidity;
    logic [15:0] temperature;
  } meas_t;

  // three-byte answer: word then checksum
  typedef struct packed {
    logic [15:0] word;
    logic [7:0] crc;
  } word_crc_t;

endpackage

/* File: src/sensor_cmd_core.sv */
// Purpose: decodes maintenance and single-shot commands, times them,
//          drives core actions and returns results
// Assumes: command words arrive already framed from the link layer
// Notes: busy is high for the whole maximum duration of each command
`timescale 1ns/1ps

module sensor_cmd_core #(
  parameter int SELF_TEST_CYC = sensor_cmd_pkg::SELF_TEST_CYC,
  parameter int FACTORY_RESET_CYC = sensor_cmd_pkg::FACTORY_RESET_CYC,
  parameter int REINIT_CYC = sensor_cmd_pkg::REINIT_CYC,
  parameter int SINGLE_SHOT_CYC = sensor_cmd_pkg::SINGLE_SHOT_CYC,
  parameter longint ASC_INTERVAL_CYC = sensor_cmd_pkg::ASC_INTERVAL_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // command from link layer
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_code,
  // sensing core results
  input wire logic [15:0] i_self_test_status,
  input wire sensor_cmd_pkg::meas_t i_meas,
  input wire logic i_asc_disable,
  // actions toward sensing core
  output logic o_busy,
  output logic o_self_test_run,
  output logic o_nvm_clear_pulse,
  output logic o_cal_history_erase_pulse,
  output logic o_settings_reload_pulse,
  output logic o_measure_pulse,
  output logic o_asc_run_pulse,
  output logic o_asc_enabled,
  // answers to link layer
  output sensor_cmd_pkg::word_crc_t o_self_test_result,
  output logic o_self_test_result_valid,
  output sensor_cmd_pkg::meas_t o_meas,
  output logic o_meas_ready
);

  // ************************************************************
  // state
  // ************************************************************
  // calibration timer width; spare bit lets it saturate past the interval
  localparam int ASC_TW = $clog2(ASC_INTERVAL_CYC + 1) + 1;

  typedef struct packed {
    sensor_cmd_pkg::cmd_state_t st;
    logic [31:0] timer;
    logic [ASC_TW-1:0] asc_timer;
    logic asc_en;
    logic nvm_clear;
    logic hist_erase;
    logic reload;
    logic measure;
    logic asc_run;
    sensor_cmd_pkg::word_crc_t st_result;
    logic st_valid;
    sensor_cmd_pkg::meas_t meas;
    logic meas_ready;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  // power-up image: idle, auto baseline correction on
  localparam core_state_t RST_STATE = '{
    st: sensor_cmd_pkg::ST_IDLE,
    asc_en: sensor_cmd_pkg::ASC_EN_RESET,
    default: '0
  };

  // countdown finished
  function automatic logic expired(input logic [31:0] t);
    return t == 32'h0;
  endfunction

  // state that a command word starts; unknown words give idle
  function automatic sensor_cmd_pkg::cmd_state_t decode_cmd(
    input logic [15:0] code
  );
    if (code == sensor_cmd_pkg::CMD_SELF_TEST) begin
      return sensor_cmd_pkg::ST_SELF_TEST;
    end else if (code == sensor_cmd_pkg::CMD_FACTORY_RESET) begin
      return sensor_cmd_pkg::ST_FACTORY;
    end else if (code == sensor_cmd_pkg::CMD_REINIT) begin
      return sensor_cmd_pkg::ST_REINIT;
    end else if (code == sensor_cmd_pkg::CMD_SINGLE_SHOT) begin
      return sensor_cmd_pkg::ST_SHOT;
    end else begin
      return sensor_cmd_pkg::ST_IDLE;
    end
  endfunction

  // busy time of a command, counted down to zero
  function automatic logic [31:0] load_for(
    input sensor_cmd_pkg::cmd_state_t st
  );
    logic [31:0] n;
    case (st)
      sensor_cmd_pkg::ST_SELF_TEST: n = 32'(SELF_TEST_CYC - 1);
      sensor_cmd_pkg::ST_FACTORY: n = 32'(FACTORY_RESET_CYC - 1);
      sensor_cmd_pkg::ST_REINIT: n = 32'(REINIT_CYC - 1);
      sensor_cmd_pkg::ST_SHOT: n = 32'(SINGLE_SHOT_CYC - 1);
      default: n = 32'h0;
    endcase
    return n;
  endfunction

  // checksum over two data bytes
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = sensor_cmd_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ sensor_cmd_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // ************************************************************
  // command sequencing
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.nvm_clear = 1'b0;
    s_d.hist_erase = 1'b0;
    s_d.reload = 1'b0;
    s_d.measure = 1'b0;
    s_d.asc_run = 1'b0;
    if (!expired(s_q.timer)) begin
      s_d.timer = s_q.timer - 32'h1;
    end
    case (s_q.st)
      sensor_cmd_pkg::ST_IDLE: begin
        // unknown words decode to idle and are dropped
        if (i_cmd_valid) begin
          s_d.st = decode_cmd(i_cmd_code);
          s_d.timer = load_for(s_d.st);
        end
        case (s_d.st)
          sensor_cmd_pkg::ST_SELF_TEST: begin
            s_d.st_valid = 1'b0;
          end
          sensor_cmd_pkg::ST_FACTORY: begin
            s_d.nvm_clear = 1'b1;
            s_d.hist_erase = 1'b1;
            s_d.asc_en = sensor_cmd_pkg::ASC_EN_RESET;
            s_d.asc_timer = '0;
          end
          sensor_cmd_pkg::ST_REINIT: begin
            s_d.reload = 1'b1;
          end
          sensor_cmd_pkg::ST_SHOT: begin
            s_d.measure = 1'b1;
            s_d.meas_ready = 1'b0;
          end
          default: begin
          end
        endcase
      end
      sensor_cmd_pkg::ST_SELF_TEST: begin
        if (expired(s_q.timer)) begin
          s_d.st = sensor_cmd_pkg::ST_IDLE;
          s_d.st_result.word = i_self_test_status;
          s_d.st_result.crc = crc8(i_self_test_status);
          s_d.st_valid = 1'b1;
        end
      end
      sensor_cmd_pkg::ST_SHOT: begin
        if (expired(s_q.timer)) begin
          s_d.st = sensor_cmd_pkg::ST_IDLE;
          s_d.meas = i_meas;
          s_d.meas_ready = 1'b1;
          // calibration only when the interval has passed since the last
          if (s_q.asc_en && !i_asc_disable) begin
            if (s_q.asc_timer >= ASC_TW'(ASC_INTERVAL_CYC)) begin
              s_d.asc_run = 1'b1;
              s_d.asc_timer = '0;
            end
          end
        end
      end
      default: begin
        if (expired(s_q.timer)) begin
          s_d.st = sensor_cmd_pkg::ST_IDLE;
        end
      end
    endcase
    // elapsed time since last calibration, lost on power cycle;
    // held at zero from the factory reset command until it ends
    if (s_q.asc_timer != '1 && !s_d.asc_run &&
        s_d.st != sensor_cmd_pkg::ST_FACTORY) begin
      s_d.asc_timer = s_q.asc_timer + ASC_TW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_busy = (s_q.st != sensor_cmd_pkg::ST_IDLE);
  assign o_self_test_run = (s_q.st == sensor_cmd_pkg::ST_SELF_TEST);
  assign o_nvm_clear_pulse = s_q.nvm_clear;
  assign o_cal_history_erase_pulse = s_q.hist_erase;
  assign o_settings_reload_pulse = s_q.reload;
  assign o_measure_pulse = s_q.measure;
  assign o_asc_run_pulse = s_q.asc_run;
  assign o_asc_enabled = s_q.asc_en & ~i_asc_disable;
  assign o_self_test_result = s_q.st_result;
  assign o_self_test_result_valid = s_q.st_valid;
  assign o_meas = s_q.meas;
  assign o_meas_ready = s_q.meas_ready;

endmodule // sensor_cmd_core

/* File: bench/cmd_host_model.sv */
// Purpose: host side that issues command words
// Assumes: one word per go request
// Notes: i_rude lets a word through while busy
`timescale 1ns/1ps
module cmd_host_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request from bench
  input wire logic i_busy,
  input wire logic i_go,
  input wire logic i_rude,
  input wire logic [15:0] i_code,
  // toward core
  output logic o_cmd_valid,
  output logic [15:0] o_cmd_code
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd_code <= 16'h0000;
    end else begin
      // drops the word while busy unless rude; junk on the code when idle
      o_cmd_valid <= i_go && (!i_busy || i_rude);
      o_cmd_code <= i_go ? i_code : ~o_cmd_code;
    end
  end
endmodule // cmd_host_model

/* File: bench/cmd_monitor.sv */
// Purpose: port assertions for the command core
// Assumes: counts handed on by the bind
// Notes: one clock domain
`timescale 1ns/1ps
module cmd_mon #(
  parameter int SELF_TEST_CYC = 8,
  parameter int FACTORY_RESET_CYC = 6,
  parameter int REINIT_CYC = 4,
  parameter int SINGLE_SHOT_CYC = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_code,
  input wire logic [15:0] i_self_test_status,
  input wire logic i_asc_disable,
  input wire logic o_busy,
  input wire logic o_self_test_run,
  input wire logic o_nvm_clear_pulse,
  input wire logic o_cal_history_erase_pulse,
  input wire logic o_settings_reload_pulse,
  input wire logic o_measure_pulse,
  input wire logic o_asc_run_pulse,
  input wire logic o_asc_enabled,
  input wire sensor_cmd_pkg::word_crc_t o_self_test_result,
  input wire logic o_self_test_result_valid,
  input wire logic o_meas_ready
);
  logic go;
  logic [15:0] k_q;
  int n_q;
  int exp_n;
  assign go = i_cmd_valid && !o_busy;
  assign exp_n = k_q == sensor_cmd_pkg::CMD_SELF_TEST ? SELF_TEST_CYC :
    k_q == sensor_cmd_pkg::CMD_FACTORY_RESET ? FACTORY_RESET_CYC :
    k_q == sensor_cmd_pkg::CMD_REINIT ? REINIT_CYC : SINGLE_SHOT_CYC;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      k_q <= 16'h0000;
      n_q <= 0;
    end else begin
      if (go) k_q <= i_cmd_code;
      n_q <= o_busy ? n_q + 1 : 0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_busy_len: assert property ($fell(o_busy) |-> n_q == exp_n)
    else $error("busy length wrong");
  chk_st_start: assert property (go && i_cmd_code == 16'h3639 |=>
    o_busy && o_self_test_run && !o_self_test_result_valid) else $error("st");
  chk_st_done: assert property ($fell(o_self_test_run) |->
    o_self_test_result_valid &&
    o_self_test_result.word == $past(i_self_test_status)) else $error("res");
  chk_crc_zero: assert property (o_self_test_result_valid &&
    o_self_test_result.word == 16'h0000 |-> o_self_test_result.crc == 8'h81)
    else $error("crc");
  chk_fr_pulses: assert property (
    go && i_cmd_code == 16'h3632 |=>
    o_nvm_clear_pulse && o_cal_history_erase_pulse ##1 !o_nvm_clear_pulse)
    else $error("factory");
  chk_ri_pulse: assert property (go && i_cmd_code == 16'h3646 |=>
    o_settings_reload_pulse ##1 !o_settings_reload_pulse) else $error("re");
  chk_ss_start: assert property (go && i_cmd_code == 16'h219D |=>
    o_measure_pulse && !o_meas_ready) else $error("shot");
  chk_meas_done: assert property ($fell(o_busy) && k_q == 16'h219D
    |-> o_meas_ready) else $error("ready");
  chk_asc_level: assert property (o_asc_enabled == !i_asc_disable)
    else $error("asc level");
  chk_asc_end: assert property (o_asc_run_pulse |->
    $fell(o_busy) && k_q == 16'h219D) else $error("asc run");
  cover property (go && i_cmd_code == 16'h3639);
  cover property (o_asc_run_pulse);
  cover property (i_cmd_valid && o_busy);
endmodule // cmd_mon
bind sensor_cmd_core cmd_mon #(.SELF_TEST_CYC(SELF_TEST_CYC),
  .FACTORY_RESET_CYC(FACTORY_RESET_CYC), .REINIT_CYC(REINIT_CYC),
  .SINGLE_SHOT_CYC(SINGLE_SHOT_CYC)) i_cmd_mon (.*);

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the command core
// Assumes: shortened counts, 40 MHz clock
// Notes: host model sends the command words
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [15:0] code;
    int n;
    logic [3:0] act;
  } row_t;
  logic i_clk, i_rst_n, go, rude, dis, busy, run_st, asc_en, vld, st_ok;
  logic rdy, asc_p;
  logic [3:0] act;
  logic [15:0] code, ccode, status;
  sensor_cmd_pkg::meas_t meas, meas_o;
  sensor_cmd_pkg::word_crc_t res;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int asc_n = 0;
  row_t rows[4] = '{'{16'h3639, 8, 4'h0}, '{16'h3632, 6, 4'hC},
    '{16'h3646, 4, 4'h2}, '{16'h219D, 10, 4'h1}};
  cmd_host_model i_cmd_host_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_busy(busy), .i_go(go), .i_rude(rude), .i_code(code),
    .o_cmd_valid(vld), .o_cmd_code(ccode));
  sensor_cmd_core #(.SELF_TEST_CYC(8), .FACTORY_RESET_CYC(6),
    .REINIT_CYC(4), .SINGLE_SHOT_CYC(10), .ASC_INTERVAL_CYC(50))
    i_sensor_cmd_core (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_cmd_valid(vld), .i_cmd_code(ccode), .i_self_test_status(status),
    .i_meas(meas), .i_asc_disable(dis), .o_busy(busy),
    .o_self_test_run(run_st), .o_nvm_clear_pulse(act[3]),
    .o_cal_history_erase_pulse(act[2]), .o_settings_reload_pulse(act[1]),
    .o_measure_pulse(act[0]), .o_asc_run_pulse(asc_p),
    .o_asc_enabled(asc_en), .o_self_test_result(res),
    .o_self_test_result_valid(st_ok), .o_meas(meas_o), .o_meas_ready(rdy));
  task automatic chk(input string s, input logic [47:0] e,
    input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic send(input logic [15:0] c, input logic r);
    @(posedge i_clk);
    go <= 1'b1;
    code <= c;
    rude <= r;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic run(input row_t r);
    send(r.code, 1'b0);
    chk("act", {r.act, 1'b1}, {act, busy});
    repeat (r.n - 1) @(posedge i_clk);
    #1 chk("busy", 1, busy);
    @(posedge i_clk);
    #1 chk("done", 0, busy);
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (asc_p) asc_n++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    {i_rst_n, go, rude, dis} = 4'h0;
    code = 16'h0000;
    status = 16'h0000;
    meas = 48'h0123456789AB;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1 chk("idle", 4'h1, {busy, st_ok, rdy, asc_en});
    foreach (rows[i]) run(rows[i]);
    chk("st_res", 24'h000081, res);
    chk("meas", meas, meas_o);
    status <= 16'h8000;
    run(rows[0]);
    chk("st_bad", 16'h8000, res.word);
    chk("st_crc", 24'h8000A2, res);
    send(16'h3639, 1'b0);
    send(16'h3646, 1'b1);
    chk("refused", 0, act);
    repeat (8) @(posedge i_clk);
    send(16'h1234, 1'b0);
    chk("unknown", 0, busy);
    repeat (6) run(rows[3]);
    chk("asc_ran", 1, asc_n > 0);
    dis <= 1'b1;
    @(posedge i_clk);
    #1 chk("asc_mask", 0, asc_en);
    dis <= 1'b0;
    // let the calibration interval pass so only the reset can stop it
    repeat (50) @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    asc_n = 0;
    run(rows[3]);
    chk("asc_none", 0, asc_n);
    summarize();
  end
endmodule // testbench
